// ---- hw/afw_params.svh ----
// Register offsets, field positions and reset values for the buffer write port.
`ifndef AFW_PARAMS_SVH
`define AFW_PARAMS_SVH
`define AFW_ADR_CTRL      8'h00
`define AFW_ADR_THR_SET   8'h04
`define AFW_ADR_THR_CLR   8'h08
`define AFW_ADR_STATUS    8'h0c
`define AFW_ADR_DATA      8'h10
`define AFW_CTRL_DUAL     0
`define AFW_ST_FULL       0
`define AFW_ST_ONE_LEFT   1
`define AFW_ST_HIGH       2
`define AFW_ST_AVAIL      3
`define AFW_ST_LVL_LSB    8
`define AFW_THR_SET_RST   32'h0000_000c
`define AFW_THR_CLR_RST   32'h0000_0008
`define AFW_RST_SYNC_ON   2'h3
`endif

// ---- hw/afw_pkg.sv ----
// Shared types for the buffer write port.
`default_nettype none
package afw_pkg;
    typedef enum logic {AFW_THR_SHARED, AFW_THR_SPLIT} afw_thr_mode_t;
endpackage : afw_pkg
`default_nettype wire

// ---- hw/afw_fifo.sv ----
// Storage buffer with valid and ready on both sides and a live fill level.
`timescale 1ns/10ps
`default_nettype none
`include "afw_params.svh"
module afw_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       clr,
    // Filling side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    // Draining side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    // Fill level
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } afw_fifo_st_t;

    afw_fifo_st_t st_r;
    afw_fifo_st_t st_nxt;
    logic         push;
    logic         pop;

    // A full buffer refuses, so a write there never touches storage.
    assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];
    assign level     = st_r.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp           = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (clr) begin
            st_nxt.wp  = '0;
            st_nxt.rp  = '0;
            st_nxt.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    AST_FIFO_PUSH: assert property (@(posedge clk) disable iff (clr)
        push && !pop |=> st_r.cnt == $past(st_r.cnt) + 1'b1 && st_r.mem[$past(st_r.wp)] == $past(in_data))
        else $error("Accepted word was not stored.");
    AST_FIFO_REFUSE: assert property (@(posedge clk) disable iff (clr)
        !in_ready && !pop |=> $stable(st_r.wp) && $stable(st_r.cnt))
        else $error("Full buffer changed on a write.");
endmodule : afw_fifo
`default_nettype wire

// ---- hw/afw_write_port.sv ----
// Write-side port of a buffer, with status flags and a drain register on Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "afw_params.svh"
module afw_write_port #(
    parameter int DW    = 32,
    parameter int DEPTH = 16,
    parameter int LW    = $clog2(DEPTH) + 1
) (
    // Clock and resets
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 core_rst,
    input  wire logic                 wr_rst,
    // Write port
    input  wire logic [DW-1:0]        wr_data,
    input  wire logic                 wr_en,
    output logic                      full,
    output logic                      one_left,
    output logic                      high_mark,
    output logic [LW-1:0]             wr_level,
    output logic                      wr_ack,
    output logic                      overflow,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o
);
    localparam int FW = $clog2(DEPTH) + 1;

    typedef struct packed {
        logic [1:0]                rst_sync;
        afw_pkg::afw_thr_mode_t    mode;
        logic [FW-1:0]             thr_set;
        logic [FW-1:0]             thr_clr;
        afw_pkg::afw_thr_mode_t    act_mode;
        logic [FW-1:0]             act_set;
        logic [FW-1:0]             act_clr;
        logic                      high;
        logic [FW-1:0]             level;
        logic                      ack_ev;
        logic                      ovf_ev;
        logic                      bus_ack;
        logic [31:0]               bus_dat;
    } afw_port_st_t;

    afw_port_st_t  st_r;
    afw_port_st_t  st_nxt;
    logic          rst_all;
    logic          fifo_ready;
    logic          fifo_valid;
    logic          fifo_pop;
    logic [DW-1:0] fifo_head;
    logic [FW-1:0] live;
    logic          bus_req;
    logic          bus_wr;
    logic [FW-1:0] clr_lvl;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction : hit

    // The core reset is only seen through the second synchroniser stage.
    assign rst_all  = !nrst || wr_rst || st_r.rst_sync[1];
    assign bus_req  = wb_cyc_i && wb_stb_i;
    // Writes and pops land on the edge where the master samples ack.
    assign bus_wr   = bus_req && wb_we_i && st_r.bus_ack;
    assign fifo_pop = bus_req && !wb_we_i && st_r.bus_ack && hit(wb_adr_i, `AFW_ADR_DATA);

    afw_fifo #(
        .W     (DW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .clr       (rst_all),
        .in_valid  (wr_en),
        .in_ready  (fifo_ready),
        .in_data   (wr_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_head),
        .level     (live)
    );

    assign full      = !fifo_ready;
    assign one_left  = (live == FW'(DEPTH - 1));
    assign clr_lvl   = (st_r.act_mode == afw_pkg::AFW_THR_SPLIT) ? st_r.act_clr
                                                                 : st_r.act_set;
    // Hysteresis: once high, only the clear level or a reset can drop the flag.
    assign high_mark = !rst_all && (st_r.high ? (live >= clr_lvl)
                                              : (live >= st_r.act_set));
    // A narrow level drops low bits, so it rounds down the already lagging registered level.
    assign wr_level  = st_r.level[FW-1 -: LW];
    assign wr_ack    = st_r.ack_ev;
    assign overflow  = st_r.ovf_ev;
    assign wb_ack_o  = st_r.bus_ack;
    assign wb_dat_o  = st_r.bus_dat;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.rst_sync = {st_r.rst_sync[0], core_rst};
        st_nxt.ack_ev   = wr_en && fifo_ready;
        st_nxt.ovf_ev   = wr_en && !fifo_ready;
        st_nxt.level    = live;
        st_nxt.high     = high_mark;
        st_nxt.bus_ack  = bus_req && !st_r.bus_ack;
        if (bus_req && !st_r.bus_ack) begin
            st_nxt.bus_dat = '0;
            if (hit(wb_adr_i, `AFW_ADR_CTRL)) begin
                st_nxt.bus_dat[`AFW_CTRL_DUAL] = (st_r.mode == afw_pkg::AFW_THR_SPLIT);
            end
            if (hit(wb_adr_i, `AFW_ADR_THR_SET)) begin
                st_nxt.bus_dat[FW-1:0] = st_r.thr_set;
            end
            if (hit(wb_adr_i, `AFW_ADR_THR_CLR)) begin
                st_nxt.bus_dat[FW-1:0] = st_r.thr_clr;
            end
            if (hit(wb_adr_i, `AFW_ADR_STATUS)) begin
                st_nxt.bus_dat[`AFW_ST_FULL]     = full;
                st_nxt.bus_dat[`AFW_ST_ONE_LEFT] = one_left;
                st_nxt.bus_dat[`AFW_ST_HIGH]     = high_mark;
                st_nxt.bus_dat[`AFW_ST_AVAIL]    = fifo_valid;
                st_nxt.bus_dat[`AFW_ST_LVL_LSB +: FW] = live;
            end
            if (hit(wb_adr_i, `AFW_ADR_DATA) && fifo_valid) begin
                st_nxt.bus_dat[DW-1:0] = fifo_head;
            end
        end
        if (bus_wr && wb_sel_i[0]) begin
            if (hit(wb_adr_i, `AFW_ADR_CTRL)) begin
                st_nxt.mode = wb_dat_i[`AFW_CTRL_DUAL] ? afw_pkg::AFW_THR_SPLIT
                                                       : afw_pkg::AFW_THR_SHARED;
            end
            if (hit(wb_adr_i, `AFW_ADR_THR_SET)) begin
                st_nxt.thr_set = wb_dat_i[FW-1:0];
            end
            if (hit(wb_adr_i, `AFW_ADR_THR_CLR)) begin
                st_nxt.thr_clr = wb_dat_i[FW-1:0];
            end
        end
        // Thresholds may move at any time but only a reset loads them.
        if (rst_all) begin
            st_nxt.act_mode = st_r.mode;
            st_nxt.act_set  = st_r.thr_set;
            st_nxt.act_clr  = st_r.thr_clr;
            st_nxt.high     = 1'b0;
            st_nxt.level    = '0;
            st_nxt.ack_ev   = 1'b0;
            st_nxt.ovf_ev   = 1'b0;
        end
        if (!nrst) begin
            st_nxt.rst_sync = `AFW_RST_SYNC_ON;
            st_nxt.mode     = afw_pkg::AFW_THR_SHARED;
            st_nxt.thr_set  = FW'(`AFW_THR_SET_RST);
            st_nxt.thr_clr  = FW'(`AFW_THR_CLR_RST);
            st_nxt.bus_ack  = 1'b0;
            st_nxt.bus_dat  = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst_all);

    AST_ACK_AFTER_WRITE: assert property (
        wr_en && !full |=> wr_ack && !overflow ##1 (!wr_ack || $past(wr_en && !full)))
        else $error("Acknowledge missing or too long after accepted write.");
    AST_OVF_AFTER_FULL: assert property (
        wr_en && full |=> overflow && !wr_ack)
        else $error("Overflow missing after refused write.");
    AST_FULL_FROZEN: assert property (
        full && !fifo_pop |=> $stable(live) && full)
        else $error("Full buffer changed without a read.");
    AST_ONE_LEFT_STEP: assert property (
        one_left && wr_en && !fifo_pop |=> full && !one_left)
        else $error("One-left flag did not lead to full.");
    AST_LEVEL_LAG: assert property (
        wr_en && !full && !fifo_pop ##1 !rst_all |-> st_r.level == live - 1'b1 ##1 st_r.level == $past(live))
        else $error("Level did not follow a write by one edge.");
    AST_LEVEL_SAFE: assert property (
        {1'b0, live} <= {1'b0, st_r.level} + (FW+1)'(1))
        else $error("Level under-reports by more than the last write.");
    AST_HIGH_SET: assert property (
        live >= st_r.act_set |-> high_mark)
        else $error("High flag missing at set level.");
    AST_HIGH_CLEAR: assert property (
        $fell(high_mark) |-> live < clr_lvl)
        else $error("High flag dropped above clear level.");
    AST_THR_FROZEN: assert property (
        !rst_all ##1 !rst_all |-> $stable(st_r.act_set) && $stable(st_r.act_clr))
        else $error("Active thresholds moved outside reset.");
    AST_RESET_CLEARS: assert property (disable iff (!nrst)
        wr_rst |=> live == '0 && !wr_ack && !overflow)
        else $error("Write reset left pointers or flags set.");
    AST_CORE_SYNC: assert property (disable iff (!nrst)
        core_rst ##1 core_rst |=> rst_all)
        else $error("Core reset not seen after two edges.");
    AST_BUS_ACK: assert property (disable iff (!nrst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus acknowledge not one cycle after request.");
endmodule : afw_write_port
`default_nettype wire

// ---- dv/afw_writer.sv ----
// Model of the user logic that pushes words into the write port.
`timescale 1ns/10ps
`default_nettype none
module afw_writer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Command from the bench
    input  wire logic        start,
    input  wire logic [5:0]  n_words,
    input  wire logic [31:0] base,
    // Write side
    output logic             wr_en,
    output logic [31:0]      wr_data,
    output logic             busy
);
    logic [5:0]  left_r;
    logic [31:0] next_r;
    assign busy = (left_r != 6'h0) | wr_en;
    // It ignores full on purpose, so the bench can provoke a refused write.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            left_r  <= 6'h0;
            next_r  <= 32'h0;
            wr_en   <= 1'h0;
            wr_data <= 32'h0;
        end else if (start) begin
            left_r <= n_words;
            next_r <= base;
        end else if (left_r != 6'h0) begin
            wr_en   <= 1'h1;
            wr_data <= next_r;
            next_r  <= next_r + 32'h1;
            left_r  <= left_r - 6'h1;
        end else begin
            // Idle data toggles, so a stale word can never pass for a fresh one.
            wr_en   <= 1'h0;
            wr_data <= ~wr_data;
        end
    end
endmodule : afw_writer
`default_nettype wire

// ---- dv/tb_top.sv ----
// Testbench for the buffer write port with a writer model and a Wishbone master.
`timescale 1ns/10ps
`default_nettype none
`include "afw_params.svh"
module tb_top;
    logic        clk, nrst, core_rst, wr_rst, start, busy, wr_en;
    logic        full, one_left, high_mark, wr_ack, overflow, cyc, stb, we, ack;
    logic [5:0]  n_words;
    logic [31:0] base, wr_data, wdat, rdat, rd;
    logic [4:0]  wr_level;
    logic [2:0]  lvl_n;
    logic [7:0]  adr;
    logic [3:0]  sel;
    int          n_errors, checks, n_ack, n_ovf;

    afw_writer afw_writer_inst (.clk(clk), .nrst(nrst), .start(start), .n_words(n_words),
        .base(base), .wr_en(wr_en), .wr_data(wr_data), .busy(busy));
    afw_write_port afw_write_port_inst (.clk(clk), .nrst(nrst), .core_rst(core_rst),
        .wr_rst(wr_rst), .wr_data(wr_data), .wr_en(wr_en), .full(full), .one_left(one_left),
        .high_mark(high_mark), .wr_level(wr_level), .wr_ack(wr_ack), .overflow(overflow),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    // A copy with a narrow level output; it sees exactly the same traffic.
    afw_write_port #(.LW(3)) afw_write_port_inst2 (.clk(clk), .nrst(nrst),
        .core_rst(core_rst), .wr_rst(wr_rst), .wr_data(wr_data), .wr_en(wr_en), .full(),
        .one_left(), .high_mark(), .wr_level(lvl_n), .wr_ack(), .overflow(), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(), .wb_ack_o());

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wr_ack === 1'h1) n_ack++;
        if (overflow === 1'h1) n_ovf++;
    end

    task automatic close_out;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic give_up;
        n_errors++;
        close_out;
    endtask : give_up
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One classic cycle; read data is taken only at the edge that sees ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'h1 && i < 64);
        if (i >= 64) give_up;
        rd = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we  <= 1'h0;
        @(posedge clk);
    endtask : wb
    task automatic send(input logic [5:0] n, input logic [31:0] b);
        start   <= 1'h1;
        n_words <= n;
        base    <= b;
        @(posedge clk);
        start <= 1'h0;
    endtask : send
    // The extra edge lets the registered level and the pulse counters catch up.
    task automatic idle;
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (busy === 1'h1 && i < 64);
        if (i >= 64) give_up;
        @(posedge clk);
    endtask : idle
    task automatic drain(input int n, input int c, input logic [31:0] b, input int clr,
                         input logic hi);
        for (int k = 0; k < n; k++) begin
            wb(1'h0, `AFW_ADR_DATA, 32'h0);
            c--;
            if (c < clr) hi = 1'h0;
            chk("data word", b + k, rd);
            chk("high flag", hi, high_mark);
            chk("one-left flag", c == 15, one_left);
            chk("full flag", c == 16, full);
        end
        @(posedge clk);
        chk("fill level", c, wr_level);
    endtask : drain

    task automatic t_regs;
        wb(1'h0, `AFW_ADR_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
        // A write whose low byte lane is off must leave the register alone.
        sel <= 4'he;
        wb(1'h1, `AFW_ADR_THR_SET, 32'h1f);
        sel <= 4'hf;
        wb(1'h0, `AFW_ADR_THR_SET, 32'h0);
        chk("set level", `AFW_THR_SET_RST, rd);
        wb(1'h0, `AFW_ADR_THR_CLR, 32'h0);
        chk("clear level", `AFW_THR_CLR_RST, rd);
        wb(1'h1, 8'h20, 32'hffff_ffff);
        wb(1'h0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("level", 32'h0, wr_level);
    endtask : t_regs
    task automatic t_fill;
        int a;
        n_ack = 0;
        n_ovf = 0;
        send(6'h1, 32'ha000_0000);
        a = 0;
        do begin
            @(posedge clk);
            a++;
        end while (wr_ack !== 1'h1 && a < 16);
        if (a >= 16) give_up;
        chk("level in ack cycle", 32'h0, wr_level);
        @(posedge clk);
        chk("level after ack", 32'h1, wr_level);
        chk("ack width", 32'h0, wr_ack);
        send(6'h10, 32'ha000_0001);
        idle;
        chk("acks", 32'h10, n_ack);
        chk("overflows", 32'h1, n_ovf);
        chk("full", 32'h1, full);
        chk("one-left", 32'h0, one_left);
        chk("high", 32'h1, high_mark);
        chk("level", 32'h10, wr_level);
        chk("narrow level", 32'h4, lvl_n);
        wb(1'h0, `AFW_ADR_STATUS, 32'h0);
        chk("status", 32'h0000_100d, rd);
        drain(16, 16, 32'ha000_0000, 12, 1'h1);
        wb(1'h0, `AFW_ADR_DATA, 32'h0);
        chk("refused word", 32'h0, rd);
    endtask : t_fill
    task automatic t_split;
        wb(1'h1, `AFW_ADR_CTRL, 32'h1);
        wb(1'h0, `AFW_ADR_CTRL, 32'h0);
        chk("ctrl split", 32'h1, rd);
        wb(1'h1, `AFW_ADR_THR_SET, 32'ha);
        wb(1'h1, `AFW_ADR_THR_CLR, 32'h4);
        send(6'ha, 32'hb000_0000);
        idle;
        chk("high before reload", 32'h0, high_mark);
        wr_rst <= 1'h1;
        @(posedge clk);
        wr_rst <= 1'h0;
        repeat (2) @(posedge clk);
        chk("level after reset", 32'h0, wr_level);
        send(6'ha, 32'hc000_0000);
        idle;
        chk("high at set level", 32'h1, high_mark);
        drain(7, 10, 32'hc000_0000, 4, 1'h1);
    endtask : t_split
    task automatic t_core;
        core_rst <= 1'h1;
        repeat (5) @(posedge clk);
        chk("level in core reset", 32'h0, wr_level);
        core_rst <= 1'h0;
        repeat (4) @(posedge clk);
        wb(1'h0, `AFW_ADR_DATA, 32'h0);
        chk("emptied", 32'h0, rd);
        send(6'h1, 32'hd000_0000);
        idle;
        chk("write after reset", 32'h1, wr_level);
    endtask : t_core

    initial begin
        nrst     = 1'h0;
        core_rst = 1'h0;
        wr_rst   = 1'h0;
        start    = 1'h0;
        n_words  = 6'h0;
        base     = 32'h0;
        {cyc, stb, we} = 3'h0;
        adr      = 8'h0;
        sel      = 4'hf;
        wdat     = 32'h0;
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        repeat (3) @(posedge clk);
        t_regs;
        t_fill;
        t_split;
        t_core;
        close_out;
    end
endmodule : tb_top
`default_nettype wire
